// >>> rtl/cmf_pkg.sv
/*
  constants for the cpu operation mode and fetch control block.
  assumes a core store/load port on core_clk with 32-bit data.
*/
package cmf_pkg;
  // ********************************
  // register map
  // ********************************
  localparam logic [31:0] CMF_ADDR_PRIV   = 32'hFF2F0000;
  localparam logic [31:0] CMF_ADDR_AREA7  = 32'h1F2F0000;
  localparam logic [2:0]  CMF_SIZE_WORD   = 3'h4;
  localparam int          CMF_BIT_RSD     = 5;
  localparam int          CMF_BIT_IMU     = 3;
  localparam logic [31:0] CMF_RESET_VALUE = 32'h000003E0;
  localparam logic [31:0] CMF_WRITE_MASK  = 32'h00000028;
  // ********************************
  // fetch constants
  // ********************************
  localparam logic [31:0] CMF_AREA_SIZE   = 32'h04000000;
  localparam logic [31:0] CMF_TAIL_BYTES  = 32'h00000040;
  localparam logic [31:0] CMF_FETCH_STEP  = 32'h00000020;
  localparam int          CMF_HANG_LIMIT  = 16;
  typedef enum logic [1:0] {CMF_IDLE, CMF_REQ, CMF_HANG} cmf_fetch_type;
endpackage

// >>> rtl/cmf_prefetch.sv
/*
  always-on instruction prefetcher issuing sequential line reads.
  assumes the external bus answers with fetch_ack; no answer hangs it.
*/
`timescale 1ns/1ns
module cmf_prefetch #(
  parameter int HANG_LIMIT = cmf_pkg::CMF_HANG_LIMIT
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        redirect,
  input  wire logic [31:0] redirect_addr,
  input  wire logic        fetch_ack,
  output logic             fetch_req,
  output logic [31:0]      fetch_addr,
  output logic             fetch_hung,
  output logic             crossed_area
);
  cmf_pkg::cmf_fetch_type state_ff;
  logic [31:0]            addr_ff;
  logic [7:0]             wait_ff;
  logic                   cross_ff;
  logic [31:0]            nxt_addr;

  function automatic logic area_cross(input logic [31:0] a, input logic [31:0] b);
    area_cross = (a[31:26] != b[31:26]);
  endfunction

  assign nxt_addr     = addr_ff + cmf_pkg::CMF_FETCH_STEP;
  assign fetch_req    = (state_ff == cmf_pkg::CMF_REQ) || (state_ff == cmf_pkg::CMF_HANG);
  assign fetch_addr   = addr_ff;
  assign fetch_hung   = (state_ff == cmf_pkg::CMF_HANG);
  assign crossed_area = cross_ff;

  // ********************************
  // fetch sequencer
  // ********************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= cmf_pkg::CMF_IDLE;
      addr_ff  <= 32'h00000000;
      wait_ff  <= 8'h00;
      cross_ff <= 1'b0;
    end else begin
      case (state_ff)
        cmf_pkg::CMF_IDLE: begin
          if (redirect) begin
            addr_ff  <= redirect_addr;
            state_ff <= cmf_pkg::CMF_REQ;
          end
        end
        cmf_pkg::CMF_REQ: begin
          if (redirect) begin
            // branch or return fetch overrides the running line
            wait_ff <= 8'h00;
            addr_ff <= redirect_addr;
          end else if (fetch_ack) begin
            wait_ff  <= 8'h00;
            cross_ff <= area_cross(addr_ff, nxt_addr);
            addr_ff  <= nxt_addr;
          end else if (wait_ff == 8'(HANG_LIMIT)) begin
            state_ff <= cmf_pkg::CMF_HANG;
          end else begin
            wait_ff <= wait_ff + 8'h01;
          end
        end
        cmf_pkg::CMF_HANG: begin
          if (redirect) begin
            state_ff <= cmf_pkg::CMF_REQ;
            wait_ff  <= 8'h00;
            addr_ff  <= redirect_addr;
          end else if (fetch_ack) begin
            state_ff <= cmf_pkg::CMF_REQ; // request stays up until answered
            wait_ff  <= 8'h00;
            addr_ff  <= nxt_addr;
          end
        end
        default: state_ff <= cmf_pkg::CMF_IDLE;
      endcase
    end
  end
endmodule

// >>> rtl/cmf_mode_ctrl.sv
/*
  cpu operation mode register, return speculation and mask update policy.
  assumes core store/load port on core_clk and an external prefetcher bus.
*/
//Functional notes
//- register at two aliased addresses, 32-bit only
//- readback then exception return or invalidate
//- bit 5 disables speculative return fetch
//- bit 3 loads mask on interrupt accept
//- prefetch may cross into next area
//- unanswered prefetch read hangs the processor
//- prefetch may disturb side-effecting devices
//- speculative return fetch issued early
//- speculative fetch may hit unintended address
`timescale 1ns/1ns
module cmf_mode_ctrl #(
  parameter int HANG_LIMIT = cmf_pkg::CMF_HANG_LIMIT
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        reg_valid,
  input  wire logic        reg_write,
  input  wire logic        reg_from_core,
  input  wire logic [31:0] reg_addr,
  input  wire logic [2:0]  reg_size,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_hit,
  output logic             reg_error,
  input  wire logic        sync_event,
  input  wire logic        return_decode,
  input  wire logic [31:0] return_target,
  input  wire logic        return_commit,
  input  wire logic        redirect,
  input  wire logic [31:0] redirect_addr,
  input  wire logic        int_accept,
  input  wire logic [3:0]  int_level,
  input  wire logic [3:0]  status_interrupt_mask,
  output logic             mask_load,
  output logic [3:0]       mask_load_value,
  output logic             return_speculation_disable,
  output logic             interrupt_mask_update,
  output logic             fetch_req,
  output logic [31:0]      fetch_addr,
  input  wire logic        fetch_ack,
  output logic             fetch_hung,
  output logic             crossed_area
);
  logic [31:0] cpu_operation_mode_ff;
  logic [31:0] active_mode_ff;
  logic [31:0] rdata_ff;
  logic        readback_ff;
  logic        mask_load_ff;
  logic [3:0]  mask_value_ff;
  logic        addr_ok;
  logic        size_ok;
  logic        wr_ok;
  logic        spec_go;
  logic        pf_redirect;
  logic [31:0] pf_addr;

  // ********************************
  // register decode
  // ********************************
  assign addr_ok   = (reg_addr == cmf_pkg::CMF_ADDR_PRIV) || (reg_addr == cmf_pkg::CMF_ADDR_AREA7);
  assign size_ok   = (reg_size == cmf_pkg::CMF_SIZE_WORD);
  assign reg_hit   = reg_valid && addr_ok;
  assign reg_error = reg_hit && !size_ok;
  assign wr_ok     = reg_hit && size_ok && reg_write && reg_from_core;
  assign reg_rdata = rdata_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_operation_mode_ff <= cmf_pkg::CMF_RESET_VALUE;
    end else if (wr_ok) begin
      cpu_operation_mode_ff <= (cpu_operation_mode_ff & ~cmf_pkg::CMF_WRITE_MASK)
                             | (reg_wdata & cmf_pkg::CMF_WRITE_MASK);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_hit && size_ok && !reg_write) begin
      rdata_ff <= cpu_operation_mode_ff;
    end
  end

  // ********************************
  // setting takes effect after readback and sync
  // ********************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readback_ff <= 1'b0;
    end else if (wr_ok) begin
      readback_ff <= 1'b0;
    end else if (reg_hit && size_ok && !reg_write) begin
      readback_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_mode_ff <= cmf_pkg::CMF_RESET_VALUE;
    end else if (sync_event && readback_ff) begin
      active_mode_ff <= cpu_operation_mode_ff;
    end
  end

  assign return_speculation_disable = active_mode_ff[cmf_pkg::CMF_BIT_RSD];
  assign interrupt_mask_update      = active_mode_ff[cmf_pkg::CMF_BIT_IMU];

  // ********************************
  // interrupt mask policy
  // ********************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_load_ff  <= 1'b0;
      mask_value_ff <= 4'h0;
    end else begin
      mask_load_ff  <= int_accept && interrupt_mask_update;
      mask_value_ff <= (int_accept && interrupt_mask_update) ? int_level : status_interrupt_mask;
    end
  end

  assign mask_load       = mask_load_ff;
  assign mask_load_value = mask_value_ff;

  // ********************************
  // speculative return fetch
  // ********************************
  // decode-time target, may be wrong if the return register was abused
  assign spec_go     = return_decode && !return_speculation_disable;
  assign pf_redirect = redirect || spec_go || (return_commit && return_speculation_disable);
  assign pf_addr     = redirect ? redirect_addr : return_target;

  cmf_prefetch #(
    .HANG_LIMIT(HANG_LIMIT)
  ) u_prefetch (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .redirect     (pf_redirect),
    .redirect_addr(pf_addr),
    .fetch_ack    (fetch_ack),
    .fetch_req    (fetch_req),    // reads are real bus reads
    .fetch_addr   (fetch_addr),
    .fetch_hung   (fetch_hung),
    .crossed_area (crossed_area)
  );
endmodule

// >>> sim/cmf_mode_chk.sv
/* port checker for cmf_mode_ctrl.
   assumes a bind to the design top, same port names. */
`timescale 1ns/1ns
module cmf_mode_chk #(
  parameter int HANG_LIMIT = 16
) (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        reg_valid,
  input wire logic        reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [2:0]  reg_size,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_hit,
  input wire logic        reg_error,
  input wire logic        sync_event,
  input wire logic        return_decode,
  input wire logic [31:0] return_target,
  input wire logic        return_commit,
  input wire logic        redirect,
  input wire logic        int_accept,
  input wire logic [3:0]  int_level,
  input wire logic        mask_load,
  input wire logic [3:0]  mask_load_value,
  input wire logic        return_speculation_disable,
  input wire logic        interrupt_mask_update,
  input wire logic        fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic        fetch_ack,
  input wire logic        fetch_hung
);
  // ********************************
  // assertions
  // ********************************
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] wait_ff;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) wait_ff <= 8'h00;
    else if (fetch_req && !fetch_ack && !redirect && !(return_decode && !return_speculation_disable)
             && !(return_commit && return_speculation_disable)) wait_ff <= wait_ff + 8'h01;
    else wait_ff <= 8'h00;
  end
  addr_decode_a: assert property (reg_hit == (reg_valid && (reg_addr == 32'hFF2F0000 || reg_addr == 32'h1F2F0000)))
    else $error("alias decode wrong");
  size_refuse_a: assert property (reg_valid && reg_hit |-> reg_error == (reg_size != 3'h4))
    else $error("size error wrong");
  reserved_read_a: assert property (reg_valid && !reg_write && reg_hit && reg_size == 3'h4
    |=> (reg_rdata & 32'hFFFFFFD7) == 32'h000003C0) else $error("reserved bits wrong");
  mode_hold_a: assert property (!sync_event |=> $stable({return_speculation_disable, interrupt_mask_update}))
    else $error("setting changed without sync");
  mask_load_a: assert property (int_accept && interrupt_mask_update
    |=> mask_load && mask_load_value == $past(int_level)) else $error("mask not loaded");
  mask_keep_a: assert property (!(int_accept && interrupt_mask_update) |=> !mask_load)
    else $error("mask loaded unasked");
  fetch_step_a: assert property (fetch_req && fetch_ack && !fetch_hung && !redirect && !return_decode
    |=> fetch_addr == $past(fetch_addr) + 32'h20) else $error("fetch step wrong");
  hang_limit_a: assert property (wait_ff > HANG_LIMIT + 1 |-> fetch_hung)
    else $error("no hang on silent bus");
  hang_hold_a: assert property (fetch_hung && !fetch_ack && !redirect |=> fetch_hung && fetch_req)
    else $error("hang released");
  spec_fetch_a: assert property (return_decode && !return_speculation_disable && !redirect
    |=> fetch_req && fetch_addr == $past(return_target)) else $error("no early return fetch");
endmodule
bind cmf_mode_ctrl cmf_mode_chk #(.HANG_LIMIT(HANG_LIMIT)) cmf_mode_chk_inst (.*);

// >>> sim/test_cpu_mode_and_fetch_control.sv
/* self-checking bench for cmf_mode_ctrl.
   assumes the design top and package are compiled first. */
`timescale 1ns/1ns
module test_cpu_mode_and_fetch_control;
  `define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("unexpected %s %h %h", n, e, g); end end
  localparam logic [31:0] P4 = cmf_pkg::CMF_ADDR_PRIV;
  localparam logic [31:0] A7 = cmf_pkg::CMF_ADDR_AREA7;
  logic        core_clk, reset_n, reg_valid, reg_write, reg_from_core, sync_event, last_err;
  logic        return_decode, return_commit, redirect, int_accept, fetch_ack;
  logic [31:0] reg_addr, reg_wdata, return_target, redirect_addr, reg_rdata, fetch_addr;
  logic [2:0]  reg_size;
  logic [3:0]  int_level, status_interrupt_mask, mask_load_value;
  logic        reg_hit, reg_error, mask_load, return_speculation_disable, interrupt_mask_update;
  logic        fetch_req, fetch_hung, crossed_area;
  int          err_total, n_compared;
  cmf_mode_ctrl #(.HANG_LIMIT(4)) cmf_mode_ctrl_inst (.*);
  // ********************************
  // helpers
  // ********************************
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic acc(logic w, logic c, logic [31:0] a, logic [2:0] s, logic [31:0] d);
    {reg_valid, reg_write, reg_from_core, reg_addr, reg_size, reg_wdata} = {1'b1, w, c, a, s, d};
    #1;
    last_err = reg_error;
    cyc(1);
    reg_valid = 1'b0;
  endtask
  task automatic pulse(ref logic p);
    p = 1'b1;
    cyc(1);
    p = 1'b0;
  endtask
  task automatic apply_reset;
    reset_n = 1'b0;
    cyc(4);
    reset_n = 1'b1;
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset_refuse;
    acc(1'b0, 1'b1, A7, 3'h4, 32'h0);
    `CHK("reset", 32'h000003E0, reg_rdata)
    acc(1'b0, 1'b1, P4, 3'h2, 32'h0);
    `CHK("size", 1'b1, last_err)
    int_level = 4'hA;
    pulse(int_accept);
    `CHK("no load", 1'b0, mask_load)
    acc(1'b1, 1'b1, P4, 3'h2, 32'h0);
    acc(1'b1, 1'b0, A7, 3'h4, 32'h0);
    acc(1'b1, 1'b1, P4, 3'h4, 32'hFFFFFC3F);
    acc(1'b0, 1'b1, P4, 3'h4, 32'h0);
    `CHK("readback", 32'h000003E8, reg_rdata)
    `CHK("not yet", 1'b0, interrupt_mask_update)
    pulse(sync_event);
    `CHK("synced", 2'b11, {return_speculation_disable, interrupt_mask_update})
  endtask
  task automatic t_late_return;
    int_level = 4'h9;
    pulse(int_accept);
    `CHK("load", 5'h19, {mask_load, mask_load_value})
    redirect_addr = 32'h100;
    pulse(redirect);
    return_target = 32'h3000;
    pulse(return_decode);
    `CHK("no spec", 32'h100, fetch_addr)
    pulse(return_commit);
    `CHK("commit", 32'h3000, fetch_addr)
  endtask
  task automatic t_early_return;
    acc(1'b1, 1'b1, A7, 3'h4, 32'h000003C0); // reserved bits keep reset value
    acc(1'b0, 1'b1, A7, 3'h4, 32'h0);
    pulse(sync_event);
    `CHK("enabled", 1'b0, return_speculation_disable)
    pulse(redirect);
    return_target = 32'h2000; // target as left by subroutine call
    pulse(return_decode);
    `CHK("spec", 32'h2000, fetch_addr)
  endtask
  task automatic t_cross_hang;
    redirect_addr = 32'h03FFFFC0; // tail code on purpose, no translation block
    pulse(redirect);
    fetch_ack = 1'b1;
    cyc(1);
    `CHK("same area", 33'h003FFFFE0, {crossed_area, fetch_addr})
    cyc(1);
    fetch_ack = 1'b0;
    `CHK("cross flag", 1'b1, crossed_area)
    `CHK("next area", 32'h04000000, fetch_addr)
    cyc(8);
    `CHK("hung", 2'b11, {fetch_hung, fetch_req})
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    {reg_valid, reg_write, reg_from_core, sync_event, return_decode, return_commit, redirect, int_accept} = '0;
    {fetch_ack, reg_addr, reg_wdata, return_target, redirect_addr, reg_size, int_level} = '0;
    {status_interrupt_mask, err_total, n_compared, last_err} = '0;
    apply_reset;
    t_reset_refuse;
    t_late_return;
    apply_reset;
    t_early_return;
    apply_reset;
    t_cross_hang;
    final_report;
  end
  initial begin
    #4000;
    err_total++;
    final_report;
  end
endmodule
